// *** verilog/cssi_top.sv ***
// Card supply level selection and unit select isolation, with an APB register slave.
// Assumes all pins synchronous to CLOCK; analog supply and sequencers sit outside.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "cssi_map.svh"
module cssi_top #(
  parameter int CYC_PER_US = `CSSI_CLK_MHZ,
  parameter int LONG_US = `CSSI_T_LONG_MS * 1000,
  parameter int SHORT_US = `CSSI_T_SHORT_MS * 1000,
  parameter int PLS_MIN_US = `CSSI_T_PLS_MIN_US,
  parameter int PLS_MAX_US = `CSSI_T_PLS_MAX_US,
  // The gap floor follows the pulse floor unless set apart; both default to the same time.
  parameter int GAP_MIN_US = PLS_MIN_US
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ACTIVATION_CMD_N,
  input wire logic CARD_RESET_IN,
  input wire logic UNIT_SELECT,
  input wire logic VCC_SEL_HIGH,
  input wire logic VCC_SEL_FLOAT,
  input wire logic CARD_PRESENT,
  input wire logic EXT_CLOCK_IN,
  input wire logic HOST_DATA_LINE_I,
  output logic HOST_DATA_LINE_O,
  output logic HOST_DATA_LINE_OE,
  input wire logic CARD_IO_I,
  output logic CARD_IO_O,
  output logic CARD_IO_OE,
  output logic CARD_STATUS_O,
  output logic CARD_STATUS_OE,
  output logic [1:0] VCC_LEVEL,
  output logic SESSION_ACTIVE,
  output logic CARD_RESET_OUT,
  output logic CARD_CLOCK_OUT
);
  // The counter saturates one above the long threshold, so it never wraps.
  localparam int CW = $clog2(LONG_US + 2);
  localparam logic [CW-1:0] LONG_C = CW'(LONG_US);
  localparam logic [CW-1:0] SHORT_C = CW'(SHORT_US);
  localparam logic [CW-1:0] PMIN_C = CW'(PLS_MIN_US);
  localparam logic [CW-1:0] PMAX_C = CW'(PLS_MAX_US);
  localparam logic [CW-1:0] GAP_C = CW'(GAP_MIN_US);
  localparam logic [CW-1:0] SAT_C = CW'(LONG_US + 1);

  if (SHORT_US >= LONG_US || PLS_MIN_US > PLS_MAX_US || PLS_MAX_US >= SHORT_US
      || GAP_MIN_US >= SHORT_US || CYC_PER_US < 2 || CW > 32) begin : g_chk
    $error("cssi_top: timing parameters are inconsistent");
  end

  cssi_iso_if iso_if ();
  logic tick;
  logic card_oe;

  cssi_tick #(
    .DIV(CYC_PER_US)
  ) u_tick (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .tick(tick)
  );

  cssi_iso u_iso (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ifc(iso_if),
    .cs(UNIT_SELECT),
    .cmd_n(ACTIVATION_CMD_N),
    .rst_in(CARD_RESET_IN),
    .host_i(HOST_DATA_LINE_I),
    .host_oe(HOST_DATA_LINE_OE),
    .card_i(CARD_IO_I),
    .card_oe(card_oe),
    .status_o(CARD_STATUS_O),
    .status_oe(CARD_STATUS_OE)
  );

  // Both data lines are open-drain style: driving means pulling low.
  assign HOST_DATA_LINE_O = 1'b0;
  assign CARD_IO_O = 1'b0;
  assign CARD_IO_OE = card_oe;

  // ---------------- Register slave ----------------
  logic [1:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic acc_wr;
  logic pin_mode, cs_en;

  assign pin_mode = ctrl_q[`CSSI_CTRL_PIN_BIT];
  assign cs_en = ctrl_q[`CSSI_CTRL_CSEN_BIT];
  assign acc_wr = PSEL && PENABLE && PREADY && PWRITE;

  // Decoder state, declared here because the status read shows it.
  cssi_pkg::cssi_state_t st_q, st_d;
  cssi_pkg::cssi_vcc_t vcc_q, vcc_d;
  cssi_pkg::cssi_vcc_t pend_q, pend_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] hi_len_q, hi_len_d;
  logic pulse_q, pulse_d;
  logic prev_q, prev_d;
  logic [31:0] status_w;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`CSSI_ST_VCC_LSB +: 2] = vcc_q;
    status_w[`CSSI_ST_SESS_BIT] = st_q == cssi_pkg::CSSI_ST_SESS;
    status_w[`CSSI_ST_SEL_BIT] = iso_if.selected;
    status_w[`CSSI_ST_PULSE_BIT] = pulse_q;
    status_w[`CSSI_ST_PRES_BIT] = CARD_PRESENT;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (acc_wr && PADDR == `CSSI_OFS_CTRL) begin
      ctrl_d = PWDATA[1:0];
    end
    // Answer is prepared in the setup cycle so the access phase needs no wait.
    pready_d = PSEL && !PENABLE;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (PSEL && !PENABLE) begin
      case (PADDR)
        `CSSI_OFS_CTRL: prdata_d = {30'h0000_0000, ctrl_q};
        `CSSI_OFS_STATUS: prdata_d = status_w;
        `CSSI_OFS_HIGHTIME: prdata_d = 32'(hi_len_q);
        default: pslverr_d = 1'b1;
      endcase
    end else if (PSEL && PENABLE && !PREADY) begin
      pready_d = 1'b1;
      prdata_d = PRDATA;
      pslverr_d = PSLVERR;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= `CSSI_CTRL_RST;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      PRDATA <= prdata_d;
      PREADY <= pready_d;
      PSLVERR <= pslverr_d;
    end
  end

  // ---------------- Supply level decoder ----------------
  logic cmd;
  logic rise, fall;
  cssi_pkg::cssi_vcc_t lvl_now;
  logic sess_d, crst_d, cclk_d;

  assign cmd = iso_if.cmd_n_eff;
  assign rise = cmd && !prev_q;
  assign fall = !cmd && prev_q;

  always_comb begin
    // Level the falling edge would fix right now.
    if (pin_mode) begin
      if (VCC_SEL_FLOAT) lvl_now = cssi_pkg::CSSI_VCC_1V8;
      else if (VCC_SEL_HIGH) lvl_now = cssi_pkg::CSSI_VCC_5V0;
      else lvl_now = cssi_pkg::CSSI_VCC_3V0;
    end else if (cnt_q > LONG_C && !pulse_q) begin
      lvl_now = cssi_pkg::CSSI_VCC_5V0;
    end else begin
      // Short high, mid-range high and post-pulse high all mean 3 V.
      lvl_now = cssi_pkg::CSSI_VCC_3V0;
    end
  end

  always_comb begin
    st_d = st_q;
    vcc_d = vcc_q;
    pend_d = pend_q;
    pulse_d = pulse_q;
    hi_len_d = hi_len_q;
    prev_d = cmd;
    cnt_d = cnt_q;
    if (tick && cnt_q != SAT_C) cnt_d = cnt_q + 1'b1;
    if (rise || fall) cnt_d = '0;
    case (st_q)
      cssi_pkg::CSSI_ST_LOW: begin
        // A command already low at reset release does not start a session.
        if (rise) begin
          st_d = cssi_pkg::CSSI_ST_HIGH;
          pulse_d = 1'b0;
        end
      end
      cssi_pkg::CSSI_ST_HIGH: begin
        // The pulse window closes once the high interval reaches its ceiling.
        if (pulse_q && cnt_q >= SHORT_C) pulse_d = 1'b0;
        if (fall) begin
          hi_len_d = cnt_q;
          if (!pin_mode && !pulse_q && cnt_q >= SHORT_C) begin
            // May be the first half of a 3 V pulse pattern; hold the decision.
            st_d = cssi_pkg::CSSI_ST_PROBE;
            pend_d = lvl_now;
          end else begin
            if (pulse_q && cnt_q < GAP_C) pulse_d = 1'b0;
            st_d = cssi_pkg::CSSI_ST_SESS;
            vcc_d = lvl_now;
          end
        end
      end
      cssi_pkg::CSSI_ST_PROBE: begin
        if (rise) begin
          st_d = cssi_pkg::CSSI_ST_HIGH;
          pulse_d = cnt_q >= PMIN_C && cnt_q <= PMAX_C;
        end else if (cnt_q > PMAX_C) begin
          // Low outlasted any valid pulse: activate at the level of the edge.
          st_d = cssi_pkg::CSSI_ST_SESS;
          vcc_d = pend_q;
        end
      end
      cssi_pkg::CSSI_ST_SESS: begin
        // The level stays as fixed at activation; pin changes are not followed.
        if (rise) begin
          st_d = cssi_pkg::CSSI_ST_HIGH;
          vcc_d = cssi_pkg::CSSI_VCC_OFF;
          pulse_d = 1'b0;
        end
      end
      default: begin
        st_d = cssi_pkg::CSSI_ST_LOW;
        vcc_d = cssi_pkg::CSSI_VCC_OFF;
      end
    endcase
    sess_d = st_d == cssi_pkg::CSSI_ST_SESS;
    crst_d = sess_d && iso_if.rst_eff;
    // The card clock ignores the unit select level entirely.
    cclk_d = sess_d && EXT_CLOCK_IN;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= cssi_pkg::CSSI_ST_LOW;
      vcc_q <= cssi_pkg::CSSI_VCC_OFF;
      pend_q <= cssi_pkg::CSSI_VCC_OFF;
      cnt_q <= '0;
      hi_len_q <= '0;
      pulse_q <= 1'b0;
      // Same level as the frozen command register at reset, so no false edge follows reset.
      prev_q <= 1'b1;
      SESSION_ACTIVE <= 1'b0;
      CARD_RESET_OUT <= 1'b0;
      CARD_CLOCK_OUT <= 1'b0;
    end else begin
      st_q <= st_d;
      vcc_q <= vcc_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      hi_len_q <= hi_len_d;
      pulse_q <= pulse_d;
      prev_q <= prev_d;
      SESSION_ACTIVE <= sess_d;
      CARD_RESET_OUT <= crst_d;
      CARD_CLOCK_OUT <= cclk_d;
    end
  end

  assign VCC_LEVEL = vcc_q;

  // The session keeps running while deselected; the inputs freeze, the data relay stops and the status output is released.
  assign iso_if.cs_en = cs_en;
  assign iso_if.session = SESSION_ACTIVE;
  assign iso_if.card_present = CARD_PRESENT;
endmodule : cssi_top

// *** common/cssi_map.svh ***
// Constant map of the card supply select and isolation block.
// Assumes a 125 MHz system clock; included by bare name where needed.
//
// Function
// - Without select pin, supply level comes from the command input's high time.
// - High for more than 30 ms before falling activates at 5 V.
// - High for less than 15 ms before falling activates at 3 V.
// - After idling beyond 30 ms, the same pulse pattern activates at 3 V.
// - Select pin high gives 5 V, low gives 3 V, floating gives 1.8 V.
// - Unit select is active high; device works normally while it is high.
// - Deselect latches card reset and command inputs, ignoring later changes.
// - Deselected, host data line is released and no data passes.
// - Deselected, the card status output is released too.
// - State and session persist while deselected; live inputs resume on reselect.
// - External clock keeps feeding the card clock whatever the select level.
// - Command low starts a session; command high ends it and deactivates.
// - Outside a session, status output follows card presence.
`ifndef CSSI_MAP_SVH
`define CSSI_MAP_SVH

`define CSSI_CLK_MHZ 125
`define CSSI_T_LONG_MS 30
`define CSSI_T_SHORT_MS 15
`define CSSI_T_PLS_MIN_US 200
`define CSSI_T_PLS_MAX_US 700
`define CSSI_T_GAP_MIN_US 200

`define CSSI_OFS_CTRL 8'h00
`define CSSI_OFS_STATUS 8'h04
`define CSSI_OFS_HIGHTIME 8'h08

`define CSSI_CTRL_PIN_BIT 0
`define CSSI_CTRL_CSEN_BIT 1
`define CSSI_CTRL_RST 2'h0

`define CSSI_ST_VCC_LSB 0
`define CSSI_ST_SESS_BIT 2
`define CSSI_ST_SEL_BIT 3
`define CSSI_ST_PULSE_BIT 4
`define CSSI_ST_PRES_BIT 5

`endif

// *** common/cssi_pkg.sv ***
// Types shared by the card supply select and isolation block.
// Assumes nothing of its surroundings.
package cssi_pkg;

  typedef enum logic [1:0] {
    CSSI_VCC_OFF = 2'h0,
    CSSI_VCC_3V0 = 2'h1,
    CSSI_VCC_5V0 = 2'h2,
    CSSI_VCC_1V8 = 2'h3
  } cssi_vcc_t;

  typedef enum logic [3:0] {
    CSSI_ST_LOW = 4'h1,
    CSSI_ST_HIGH = 4'h2,
    CSSI_ST_PROBE = 4'h4,
    CSSI_ST_SESS = 4'h8
  } cssi_state_t;

  typedef enum logic [2:0] {
    CSSI_DIR_IDLE = 3'h1,
    CSSI_DIR_HOST = 3'h2,
    CSSI_DIR_CARD = 3'h4
  } cssi_dir_t;

endpackage : cssi_pkg

// *** common/cssi_iso_if.sv ***
// Carrier between the top level and the isolation unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface cssi_iso_if;
  logic cs_en;
  logic session;
  logic card_present;
  logic cmd_n_eff;
  logic rst_eff;
  logic selected;

  modport top (
    output cs_en,
    output session,
    output card_present,
    input cmd_n_eff,
    input rst_eff,
    input selected
  );

  modport iso (
    input cs_en,
    input session,
    input card_present,
    output cmd_n_eff,
    output rst_eff,
    output selected
  );
endinterface : cssi_iso_if

// *** verilog/cssi_tick.sv ***
// Microsecond enable divider.
// Assumes one clock; the pulse lasts one cycle.
`timescale 1ns/1ns
module cssi_tick #(
  parameter int DIV = 125
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int W = $clog2(DIV);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  if (DIV < 2) begin : g_chk
    $error("cssi_tick: DIV must be at least 2");
  end

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 1'b1;
    if (cnt_q == W'(DIV - 1)) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : cssi_tick

// *** verilog/cssi_iso.sv ***
// Unit select isolation: input freeze, host data relay and status release.
// Assumes host-side pins are synchronous and the lines are pulled up outside.
`timescale 1ns/1ns
module cssi_iso (
  input wire logic clk,
  input wire logic rst_n,
  cssi_iso_if.iso ifc,
  input wire logic cs,
  input wire logic cmd_n,
  input wire logic rst_in,
  input wire logic host_i,
  output logic host_oe,
  input wire logic card_i,
  output logic card_oe,
  output logic status_o,
  output logic status_oe
);
  logic sel;
  logic cmd_q, cmd_d, rst_q, rst_d;
  cssi_pkg::cssi_dir_t dir_q, dir_d;
  logic host_oe_d, card_oe_d, st_o_d;

  assign sel = !ifc.cs_en || cs;

  always_comb begin
    cmd_d = cmd_q;
    rst_d = rst_q;
    if (sel) begin
      cmd_d = cmd_n;
      rst_d = rst_in;
    end
    dir_d = dir_q;
    case (dir_q)
      cssi_pkg::CSSI_DIR_IDLE: begin
        if (!host_i) dir_d = cssi_pkg::CSSI_DIR_HOST;
        else if (!card_i) dir_d = cssi_pkg::CSSI_DIR_CARD;
      end
      cssi_pkg::CSSI_DIR_HOST: if (host_i) dir_d = cssi_pkg::CSSI_DIR_IDLE;
      cssi_pkg::CSSI_DIR_CARD: if (card_i) dir_d = cssi_pkg::CSSI_DIR_IDLE;
      default: dir_d = cssi_pkg::CSSI_DIR_IDLE;
    endcase
    if (!sel || !ifc.session) dir_d = cssi_pkg::CSSI_DIR_IDLE;
    host_oe_d = dir_d == cssi_pkg::CSSI_DIR_CARD;
    card_oe_d = dir_d == cssi_pkg::CSSI_DIR_HOST;
    st_o_d = ifc.session || ifc.card_present;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= 1'b1;
      rst_q <= 1'b0;
      dir_q <= cssi_pkg::CSSI_DIR_IDLE;
      host_oe <= 1'b0;
      card_oe <= 1'b0;
      status_o <= 1'b0;
      status_oe <= 1'b0;
      ifc.selected <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      rst_q <= rst_d;
      dir_q <= dir_d;
      host_oe <= host_oe_d;
      card_oe <= card_oe_d;
      status_o <= st_o_d;
      status_oe <= sel;
      ifc.selected <= sel;
    end
  end

  assign ifc.cmd_n_eff = cmd_q;
  assign ifc.rst_eff = rst_q;
endmodule : cssi_iso

// *** dv/cssi_props.sv ***
// Port-level checker for the supply select and isolation top level.
// Assumes one clock domain; the chip-select enable is shadowed from APB writes.
`timescale 1ns/1ns
module cssi_props (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic ACTIVATION_CMD_N,
  input wire logic UNIT_SELECT,
  input wire logic CARD_PRESENT,
  input wire logic EXT_CLOCK_IN,
  input wire logic HOST_DATA_LINE_OE,
  input wire logic CARD_STATUS_O,
  input wire logic CARD_STATUS_OE,
  input wire logic [1:0] VCC_LEVEL,
  input wire logic SESSION_ACTIVE,
  input wire logic CARD_CLOCK_OUT
);
  // The enable register is internal, so the checker follows the writes to it.
  logic csen_q;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      csen_q <= 1'b0;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00) begin
      csen_q <= PWDATA[1];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sess_vcc_on_a: assert property (
    SESSION_ACTIVE && $past(SESSION_ACTIVE) |-> VCC_LEVEL != 2'h0) else $error("no supply");
  vcc_hold_a: assert property (
    SESSION_ACTIVE && $past(SESSION_ACTIVE) |-> $stable(VCC_LEVEL)) else $error("level moved");
  idle_vcc_off_a: assert property (
    !SESSION_ACTIVE [*3] |-> VCC_LEVEL == 2'h0) else $error("supply while idle");
  rise_ends_a: assert property (
    !csen_q && $rose(ACTIVATION_CMD_N) |-> ##[1:6] !SESSION_ACTIVE) else $error("no end");
  status_rel_a: assert property (
    (csen_q && !UNIT_SELECT) [*3] |-> !CARD_STATUS_OE) else $error("status driven");
  host_rel_a: assert property (
    (csen_q && !UNIT_SELECT) [*3] |-> !HOST_DATA_LINE_OE) else $error("host line driven");
  status_pres_a: assert property (
    (CARD_STATUS_OE && !SESSION_ACTIVE && $stable(CARD_PRESENT)) [*3]
    |-> CARD_STATUS_O == CARD_PRESENT) else $error("status not presence");
  clock_pass_a: assert property (
    SESSION_ACTIVE [*3] |-> $past(CARD_CLOCK_OUT) == $past(EXT_CLOCK_IN, 2))
    else $error("card clock lost");
  cover property (SESSION_ACTIVE && VCC_LEVEL == 2'h2);
  cover property (SESSION_ACTIVE && VCC_LEVEL == 2'h3);
  cover property (csen_q && !UNIT_SELECT && SESSION_ACTIVE);
endmodule : cssi_props
bind cssi_top cssi_props u_props (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .ACTIVATION_CMD_N(ACTIVATION_CMD_N), .UNIT_SELECT(UNIT_SELECT), .CARD_PRESENT(CARD_PRESENT),
  .EXT_CLOCK_IN(EXT_CLOCK_IN), .HOST_DATA_LINE_OE(HOST_DATA_LINE_OE),
  .CARD_STATUS_O(CARD_STATUS_O), .CARD_STATUS_OE(CARD_STATUS_OE), .VCC_LEVEL(VCC_LEVEL),
  .SESSION_ACTIVE(SESSION_ACTIVE), .CARD_CLOCK_OUT(CARD_CLOCK_OUT));

// *** dv/cssi_host.sv ***
// Host controller model driving the active-low activation command.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
module cssi_host #(
  parameter int CYC = 2,
  parameter int PLS_US = 9,
  parameter int GAP_US = 10
) (
  input wire logic clk,
  output logic cmd_n
);
  initial cmd_n = 1'b0;
  task automatic wait_us(input int us);
    repeat (us * CYC) @(posedge clk);
  endtask : wait_us
  // A new level is only asked for after a rise has ended the session.
  task automatic activate(input int hi_us, input bit pulse);
    cmd_n <= 1'b1;
    wait_us(hi_us);
    if (pulse) begin
      cmd_n <= 1'b0;
      wait_us(PLS_US);
      cmd_n <= 1'b1;
      wait_us(GAP_US);
    end
    cmd_n <= 1'b0;
  endtask : activate
  task automatic set(input logic v);
    cmd_n <= v;
  endtask : set
endmodule : cssi_host

// *** dv/cssi_top_tb.sv ***
// Self-checking bench for the supply select and isolation top level.
// Assumes shortened timing parameters; open-drain lines are pulled up here.
`timescale 1ns/1ns
module cssi_top_tb;
  localparam int LONG = 60;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, pl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic cmd_n, crst, usel, shi, sfl, pres, xclk, hpull, cpull;
  logic hoe, coe, st_o, st_oe, sess, rst_out, cclk;
  logic [1:0] vcc;
  logic [4:0] pmask = 5'h18;
  int hs[5] = '{80, 10, 45, 45, 80};
  int fail_count, checks_done, cyc, h;
  cssi_top #(.CYC_PER_US(2), .LONG_US(LONG), .SHORT_US(30), .PLS_MIN_US(4),
    .PLS_MAX_US(14)) u_dut (
    .CLOCK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ACTIVATION_CMD_N(cmd_n), .CARD_RESET_IN(crst), .UNIT_SELECT(usel), .VCC_SEL_HIGH(shi),
    .VCC_SEL_FLOAT(sfl), .CARD_PRESENT(pres), .EXT_CLOCK_IN(xclk),
    .HOST_DATA_LINE_I(~(hpull | hoe)), .HOST_DATA_LINE_O(), .HOST_DATA_LINE_OE(hoe),
    .CARD_IO_I(~(cpull | coe)), .CARD_IO_O(), .CARD_IO_OE(coe), .CARD_STATUS_O(st_o),
    .CARD_STATUS_OE(st_oe), .VCC_LEVEL(vcc), .SESSION_ACTIVE(sess), .CARD_RESET_OUT(rst_out),
    .CARD_CLOCK_OUT(cclk));
  cssi_host u_host (.clk(clk), .cmd_n(cmd_n));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [1:0] exp_vcc(input int hi, input bit p);
    return (hi > LONG && !p) ? 2'h2 : 2'h1;
  endfunction : exp_vcc
  function automatic logic [1:0] pin_vcc(input bit hi, input bit fl);
    return fl ? 2'h3 : (hi ? 2'h2 : 2'h1);
  endfunction : pin_vcc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  // Starting on a fresh edge keeps back-to-back calls from driving psel twice at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    xclk <= ~xclk;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, crst, shi, sfl, xclk, hpull, cpull} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    usel = 1'b1;
    pres = 1'b1;
    seed = 32'h30;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk(st_o, 1'b1);
    chk(sess, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      h = 2 + int'(seed % 32'h76);
      if (h inside {[27:33], [57:63]}) h += 8;
      if (i < 5) h = hs[i];
      pl = (i < 5) ? pmask[i] : seed[8];
      u_host.activate(h, pl);
      repeat (40) @(posedge clk);
      chk(vcc, exp_vcc(h, pl));
      chk(sess, 1'b1);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[3:0], {2'h3, exp_vcc(h, pl)});
    apb(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 3; i++) begin
      shi <= i[0];
      sfl <= i[1];
      u_host.activate(5, 1'b0);
      repeat (8) @(posedge clk);
      chk(vcc, pin_vcc(i[0], i[1]));
    end
    apb(1'b1, 8'h00, 32'h2);
    u_host.activate(5, 1'b0);
    crst <= 1'b1;
    repeat (8) @(posedge clk);
    hpull <= 1'b1;
    repeat (4) @(posedge clk);
    chk(coe, 1'b1);
    chk(rst_out, 1'b1);
    hpull <= 1'b0;
    repeat (4) @(posedge clk);
    cpull <= 1'b1;
    repeat (4) @(posedge clk);
    chk(hoe, 1'b1);
    chk(coe, 1'b0);
    cpull <= 1'b0;
    repeat (4) @(posedge clk);
    chk(hoe, 1'b0);
    usel <= 1'b0;
    repeat (3) @(posedge clk);
    chk(st_oe, 1'b0);
    chk(hoe, 1'b0);
    u_host.set(1'b1);
    crst <= 1'b0;
    hpull <= 1'b1;
    cpull <= 1'b1;
    repeat (10) @(posedge clk);
    chk(hoe, 1'b0);
    chk(sess, 1'b1);
    chk(rst_out, 1'b1);
    chk(coe, 1'b0);
    hpull <= 1'b0;
    cpull <= 1'b0;
    usel <= 1'b1;
    repeat (6) @(posedge clk);
    chk(sess, 1'b0);
    chk(st_oe, 1'b1);
    pres <= 1'b0;
    repeat (3) @(posedge clk);
    chk(st_o, 1'b0);
    print_verdict();
  end
endmodule : cssi_top_tb
